// file: shared/uart_irq_defs.vh
// Constants for the interrupt prioritiser, FIFO control and line format block.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data, two channels.
`ifndef UART_IRQ_DEFS_VH
`define UART_IRQ_DEFS_VH

// ----------------------------------------
// Register offsets (word index in address bits 3:2, per channel)
// ----------------------------------------
`define OFS_STATUS 2'h0
`define OFS_FIFO_CTRL 2'h1
`define OFS_LINE_FMT 2'h2
`define OFS_ENH_FEAT 2'h3
`define CHAN_STRIDE_BIT 4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FC_ENABLE 0
`define FC_RX_RESET 1
`define FC_TX_RESET 2
`define FC_DMA 3
`define FC_TX_TRIG 5:4
`define FC_RX_TRIG 7:6
`define LF_LEN 1:0
`define EF_ENABLE 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_LINE_FMT 8'h00
`define RST_ENH_FEAT 8'h00
`define RST_TRIG 2'h0

// ----------------------------------------
// Status source codes, bits 5:0
// ----------------------------------------
`define CODE_LINE_ERR 6'h06
`define CODE_RX_TMO 6'h0C
`define CODE_RX_DATA 6'h04
`define CODE_TX_READY 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF_SPEC 6'h10
`define CODE_FLOW 6'h20
`define CODE_NONE 6'h01

// ----------------------------------------
// Trigger levels, FIFO depth and time-out
// ----------------------------------------
`define TRIG_L0 5'h01
`define TRIG_L1 5'h04
`define TRIG_L2 5'h08
`define TRIG_L3 5'h0E
`define FIFO_DEPTH 5'h10
`define TMO_CHARS 4
`define TMO_BITS 12
`define FRAME_EXTRA 2

`endif

// file: hdl/uart_irq_fifo_line_ctrl.v
// Interrupt source prioritiser, FIFO control and word length for two channels.
// Assumes fill counts and event pulses come from channel logic on ref_clk.
//
// What this block does
// - Line error: level 1, code 000110.
// - Receive time-out: level 2, code 001100.
// - Receive trigger reached: level 3, code 000100.
// - Transmit ready 000010; modem change 000000.
// - Xoff or special match: level 6, 010000.
// - Flow line change: level 7, 100000.
// - Nothing pending reads 000001, also after reset.
// - Bit 4 needs enhanced bit; read clears.
// - Bit 5 needs enhanced bit; flags deasserted flow.
// - Bits 7:6 read 11 when FIFOs enabled.
// - Enable bit must accompany other FIFO bits.
// - Bit 1 pulses receive FIFO pointer reset.
// - Bit 2 pulses transmit FIFO pointer reset.
// - Bit 3 selects DMA mode for ready pins.
// - Transmit trigger 1/4/8/14, needs enhanced bit.
// - Transmit interrupt below trigger or empty.
// - Receive trigger 1/4/8/14 raises receive interrupt.
// - Line bits 1:0 give 5 to 8 bits.
// - Highest pending reported, lower ones stay queued.
// - Time-out after 4 chars plus 12 bits.
// - Transmit ready clears on status read or write.
`include "uart_irq_defs.vh"

module uart_irq_fifo_line_ctrl (
	input wire ref_clk, // Device clock, 20 MHz
	input wire rst_n, // Synchronous reset, active low
	input wire [5:0] address, // Avalon byte address
	input wire read, // Avalon read request
	input wire write, // Avalon write request
	input wire [31:0] writedata, // Avalon write data
	input wire [3:0] byteenable, // Avalon byte lanes
	output reg [31:0] readdata, // Avalon read data
	output wire waitrequest, // Avalon wait, high stalls
	input wire [9:0] rx_count, // Receive FIFO fill, 5 bits per channel
	input wire [9:0] tx_count, // Transmit FIFO fill, 5 bits per channel
	input wire [1:0] line_error_status, // Any line error flag, level
	input wire [1:0] modem_line_status, // Any modem change flag, level
	input wire [1:0] xoff_match, // Xoff character detected, pulse
	input wire [1:0] xon_match, // Xon character detected, pulse
	input wire [1:0] special_match, // Special character detected, pulse
	input wire [1:0] rx_char_strobe, // A character was received, pulse
	input wire [1:0] flow_deassert, // Flow line deasserted, pulse
	input wire [1:0] flow_int_clear, // Modem status read, pulse
	input wire [1:0] rx_hold_read, // Receive holding reg read, pulse
	input wire [1:0] tx_hold_write, // Transmit holding reg write, pulse
	input wire [1:0] bit_tick, // One pulse per bit time
	output wire [1:0] fifo_enable, // FIFOs enabled
	output wire [1:0] dma_mode, // DMA mode of ready pins
	output wire [1:0] rx_fifo_reset, // Receive pointer reset, pulse
	output wire [1:0] tx_fifo_reset, // Transmit pointer reset, pulse
	output wire [7:0] char_bits, // Character length, 4 bits per channel
	output wire [15:0] line_format, // Whole line format byte per channel
	output wire [1:0] enhanced_enable, // Enhanced features on
	output wire [1:0] receive_ready_pin_n, // Receive ready pin, active low
	output wire [1:0] transmit_ready_pin_n // Transmit ready pin, active low
);

	// ----------------------------------------
	// Decoding functions
	// ----------------------------------------

	// Trigger code to character count
	function [4:0] trig_level;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: trig_level = `TRIG_L0;
				2'h1: trig_level = `TRIG_L1;
				2'h2: trig_level = `TRIG_L2;
				default: trig_level = `TRIG_L3;
			endcase
		end
	endfunction

	// Word length code to data bits
	function [3:0] char_len;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: char_len = 4'h5;
				2'h1: char_len = 4'h6;
				2'h2: char_len = 4'h7;
				default: char_len = 4'h8;
			endcase
		end
	endfunction

	// Pick the highest pending source; src[0] is highest
	function [5:0] prio_code;
		input [6:0] src;
		begin
			if (src[0])
				prio_code = `CODE_LINE_ERR;
			else if (src[1])
				prio_code = `CODE_RX_TMO;
			else if (src[2])
				prio_code = `CODE_RX_DATA;
			else if (src[3])
				prio_code = `CODE_TX_READY;
			else if (src[4])
				prio_code = `CODE_MODEM;
			else if (src[5])
				prio_code = `CODE_XOFF_SPEC;
			else if (src[6])
				prio_code = `CODE_FLOW;
			else
				prio_code = `CODE_NONE;
		end
	endfunction

	// ----------------------------------------
	// Avalon slave handshake
	// ----------------------------------------

	reg ack;
	wire req;
	wire done;
	wire mapped;
	wire [15:0] rd_bytes;

	assign req = read | write;
	assign done = req & ack;
	assign mapped = (address[5] == 1'b0);
	// One wait state: request taken on the edge where ack is high
	assign waitrequest = req & ~ack;

	// Acknowledge and capture read data one cycle after the request
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ack <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			ack <= req & ~ack;
			if (req & ~ack) begin
				if (read & mapped)
					readdata <= {24'h000000, rd_bytes[address[`CHAN_STRIDE_BIT]*8 +: 8]};
				else
					readdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Per-channel logic
	// ----------------------------------------

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			localparam integer CHI = ch;
			localparam [0:0] CH = CHI[0];
			// Channel registers
			reg fifo_en;
			reg dma;
			reg [1:0] rx_sel;
			reg [1:0] tx_sel;
			reg [7:0] lfmt;
			reg [7:0] enhanced_feature_reg;
			reg rx_rst;
			reg tx_rst;
			reg tx_flag;
			reg xoff_flag;
			reg spec_flag;
			reg flow_flag;
			reg tmo_flag;
			reg [4:0] tx_prev;
			reg tx_filled_over;
			reg [5:0] tmo_cnt;
			reg rx_pin_n;
			reg tx_pin_n;
			// Channel nets
			wire [4:0] rxc;
			wire [4:0] txc;
			wire [4:0] rx_trig;
			wire [4:0] tx_trig;
			wire [5:0] tmo_limit;
			wire [31:0] tmo_full;
			wire sel;
			wire wr_en;
			wire wr_fc;
			wire rd_st;
			wire tx_clr;
			wire match_clr;
			wire enh;
			wire rx_data_src;
			wire tx_set;
			wire tmo_run;
			wire [5:0] code;
			wire [7:0] status;
			reg [7:0] rd_byte;

			// Fill counts, trigger levels and enhanced bit of this channel
			assign rxc = rx_count[ch*5 +: 5];
			assign txc = tx_count[ch*5 +: 5];
			assign rx_trig = trig_level(rx_sel);
			assign tx_trig = trig_level(tx_sel);
			assign enh = enhanced_feature_reg[`EF_ENABLE];
			// Each channel decodes only its own address window
			assign sel = mapped & (address[`CHAN_STRIDE_BIT] == CH);
			assign wr_en = done & write & sel & byteenable[0];
			assign wr_fc = wr_en & (address[3:2] == `OFS_FIFO_CTRL);
			assign rd_st = done & read & sel & (address[3:2] == `OFS_STATUS);

			// A status read clears only the source it reported; lower ones stay queued
			assign tx_clr = rd_st & (readdata[5:0] == `CODE_TX_READY);
			assign match_clr = rd_st & (readdata[5:0] == `CODE_XOFF_SPEC);

			// Four frames (start, data, stop) plus twelve bit times
			assign tmo_full = `TMO_CHARS * (char_len(lfmt[`LF_LEN]) + `FRAME_EXTRA) + `TMO_BITS;
			assign tmo_limit = tmo_full[5:0]; // At most 52, fits six bits

			// Receive data source: trigger in FIFO mode, any data otherwise
			assign rx_data_src = fifo_en ? (rxc >= rx_trig) : (rxc != 5'h00);

			// Transmit: fell below trigger, or emptied without filling over it
			assign tx_set = fifo_en ? ((tx_prev >= tx_trig) & (txc < tx_trig)) |
				((tx_prev != 5'h00) & (txc == 5'h00) & ~tx_filled_over) :
				((tx_prev != 5'h00) & (txc == 5'h00));

			// Timer only runs while the FIFO holds data
			assign tmo_run = fifo_en & (rxc != 5'h00);

			// Queued sources stay pending until their own clear
			assign code = prio_code({flow_flag & enh, (xoff_flag | spec_flag) & enh,
				modem_line_status[ch], tx_flag, rx_data_src, tmo_flag, line_error_status[ch]});
			assign status = {fifo_en, fifo_en, code};

			// Register read multiplexer
			always @* begin
				case (address[3:2])
					`OFS_STATUS: rd_byte = status;
					`OFS_LINE_FMT: rd_byte = lfmt;
					`OFS_ENH_FEAT: rd_byte = enhanced_feature_reg;
					default: rd_byte = 8'h00;
				endcase
			end
			assign rd_bytes[ch*8 +: 8] = rd_byte;

			// Software-written control registers
			always @(posedge ref_clk) begin
				if (!rst_n) begin
					fifo_en <= 1'b0;
					dma <= 1'b0;
					rx_sel <= `RST_TRIG;
					tx_sel <= `RST_TRIG;
					lfmt <= `RST_LINE_FMT;
					enhanced_feature_reg <= `RST_ENH_FEAT;
					rx_rst <= 1'b0;
					tx_rst <= 1'b0;
				end else begin
					rx_rst <= 1'b0;
					tx_rst <= 1'b0;
					if (wr_fc) begin
						fifo_en <= writedata[`FC_ENABLE];
						if (writedata[`FC_ENABLE]) begin
							rx_rst <= writedata[`FC_RX_RESET];
							tx_rst <= writedata[`FC_TX_RESET];
							dma <= writedata[`FC_DMA];
							rx_sel <= writedata[`FC_RX_TRIG];
							if (enh)
								tx_sel <= writedata[`FC_TX_TRIG];
						end
					end
					if (wr_en && address[3:2] == `OFS_LINE_FMT)
						lfmt <= writedata[7:0];
					if (wr_en && address[3:2] == `OFS_ENH_FEAT)
						enhanced_feature_reg <= writedata[7:0];
				end
			end

			// Sticky sources; a set in the clear cycle wins
			always @(posedge ref_clk) begin
				if (!rst_n) begin
					tx_flag <= 1'b0;
					xoff_flag <= 1'b0;
					spec_flag <= 1'b0;
					flow_flag <= 1'b0;
					tx_prev <= 5'h00;
					tx_filled_over <= 1'b0;
				end else begin
					tx_prev <= txc;
					if (txc == 5'h00)
						tx_filled_over <= 1'b0;
					else if (txc > tx_trig)
						tx_filled_over <= 1'b1;
					tx_flag <= (tx_flag & ~tx_clr & ~tx_hold_write[ch]) | tx_set;
					xoff_flag <= (xoff_flag & ~match_clr & ~xon_match[ch]) | (xoff_match[ch] & enh);
					spec_flag <= (spec_flag & ~match_clr & ~rx_char_strobe[ch]) | (special_match[ch] & enh);
					flow_flag <= (flow_flag & ~flow_int_clear[ch]) | (flow_deassert[ch] & enh);
				end
			end

			// Receive time-out timer counted in bit times
			always @(posedge ref_clk) begin
				if (!rst_n) begin
					tmo_cnt <= 6'h00;
					tmo_flag <= 1'b0;
				end else begin
					if (!tmo_run || rx_char_strobe[ch] || rx_hold_read[ch])
						tmo_cnt <= 6'h00;
					else if (bit_tick[ch] && tmo_cnt != tmo_limit)
						tmo_cnt <= tmo_cnt + 6'h01;
					tmo_flag <= (tmo_flag & ~rx_hold_read[ch]) |
						(tmo_run & bit_tick[ch] & ~rx_char_strobe[ch] & ~rx_hold_read[ch] &
						(tmo_cnt + 6'h01 == tmo_limit));
				end
			end

			// Ready pins: single-character or DMA block signalling
			always @(posedge ref_clk) begin
				if (!rst_n) begin
					rx_pin_n <= 1'b1;
					tx_pin_n <= 1'b0;
				end else begin
					if (dma) begin
						rx_pin_n <= ~(rx_data_src | tmo_flag);
						tx_pin_n <= ~(txc < `FIFO_DEPTH);
					end else begin
						rx_pin_n <= (rxc == 5'h00);
						tx_pin_n <= (txc != 5'h00);
					end
				end
			end

			// Channel outputs
			assign fifo_enable[ch] = fifo_en;
			assign dma_mode[ch] = dma;
			assign rx_fifo_reset[ch] = rx_rst;
			assign tx_fifo_reset[ch] = tx_rst;
			assign char_bits[ch*4 +: 4] = char_len(lfmt[`LF_LEN]);
			assign line_format[ch*8 +: 8] = lfmt;
			assign enhanced_enable[ch] = enh;
			assign receive_ready_pin_n[ch] = rx_pin_n;
			assign transmit_ready_pin_n[ch] = tx_pin_n;
		end
	endgenerate

endmodule

// file: bench/uart_irq_checker.sv
// Checker for bus timing and the channel 0 control register effects.
// Assumes it is bound to the block's top module and sees only its ports.
module uart_irq_checker (
	input wire ref_clk, // Clock
	input wire rst_n, // Reset, low
	input wire [5:0] address, // Address
	input wire read, // Read
	input wire write, // Write
	input wire [31:0] writedata, // Write data
	input wire [3:0] byteenable, // Lanes
	input wire [31:0] readdata, // Read data
	input wire waitrequest, // Stall
	input wire [1:0] fifo_enable, // FIFO on
	input wire [1:0] dma_mode, // DMA mode
	input wire [1:0] rx_fifo_reset, // Rx reset
	input wire [1:0] tx_fifo_reset, // Tx reset
	input wire [7:0] char_bits, // Length
	input wire [15:0] line_format // Format
);
	timeunit 1ns;
	timeprecision 1ns;
	// Completed accesses
	wire fc_wr = write & ~waitrequest & byteenable[0] & (address == 6'h04);
	wire rd_ok = read & ~waitrequest;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_one_wait: assert property ((read | write) & waitrequest |=> ~waitrequest)
		else $error("wait state is not one cycle");
	chk_ack_clears: assert property ((read | write) & ~waitrequest |=> waitrequest | ~(read | write))
		else $error("no wait state on next request");
	chk_unmapped_read: assert property (rd_ok & address[5] |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_status_fifo: assert property (rd_ok & (address == 6'h00) |-> readdata[7:6] == {2{fifo_enable[0]}})
		else $error("status FIFO bits wrong");
	chk_fifo_load: assert property (fc_wr |=> fifo_enable[0] == $past(writedata[0]))
		else $error("FIFO enable not loaded");
	chk_rx_reset: assert property (fc_wr & (writedata[1:0] == 2'h3) |=> rx_fifo_reset[0] ##1 ~rx_fifo_reset[0])
		else $error("rx reset pulse wrong");
	chk_tx_reset: assert property (fc_wr & writedata[0] & writedata[2] |=> tx_fifo_reset[0] ##1 ~tx_fifo_reset[0])
		else $error("tx reset pulse wrong");
	chk_no_reset: assert property (fc_wr & ~writedata[0] |=> ~rx_fifo_reset[0] & ~tx_fifo_reset[0])
		else $error("reset without enable bit");
	chk_dma_load: assert property (fc_wr & writedata[0] |=> dma_mode[0] == $past(writedata[3]))
		else $error("DMA mode not loaded");
	chk_char_len: assert property (char_bits[3:0] == line_format[1:0] + 4'h5)
		else $error("character length wrong");
endmodule

bind uart_irq_fifo_line_ctrl uart_irq_checker u_chk (.ref_clk, .rst_n, .address, .read, .write, .writedata,
	.byteenable, .readdata, .waitrequest, .fifo_enable, .dma_mode, .rx_fifo_reset, .tx_fifo_reset,
	.char_bits, .line_format);

// file: bench/host_bus_model.sv
// Host model: an Avalon-MM master doing single reads and writes.
// Assumes the slave may stall for any number of cycles.
module host_bus_model (
	input wire ref_clk, // Clock
	input wire waitrequest, // Stall
	input wire [31:0] readdata, // Read data
	output logic [5:0] address, // Address
	output logic read, // Read
	output logic write, // Write
	output logic [31:0] writedata, // Write data
	output logic [3:0] byteenable // Lanes
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		address = 6'h00;
		read = 1'h0;
		write = 1'h0;
		writedata = 32'h0;
		byteenable = 4'hF;
	end
	// Held until waitrequest is seen low at an edge
	task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= {24'h0, d};
		write <= 1'h1;
		do @(posedge ref_clk); while (waitrequest !== 1'h0);
		write <= 1'h0;
	endtask
	task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		read <= 1'h1;
		do @(posedge ref_clk); while (waitrequest !== 1'h0);
		d = readdata;
		read <= 1'h0;
	endtask
endmodule

// file: bench/testbench.sv
// Testbench: register tests on channel 0 through the host model.
// Assumes the host model and checker are compiled before it.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [9:0] rx_count = 10'h000;
	logic [9:0] tx_count = 10'h021;
	logic [1:0] lv = 2'h0;
	logic [8:0] ev = 9'h0;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	wire [5:0] address;
	wire [31:0] writedata, readdata;
	wire [3:0] byteenable;
	wire read, write, waitrequest;
	wire [1:0] fifo_enable, dma_mode, rx_fifo_reset, tx_fifo_reset, enhanced_enable, rxp_n, txp_n;
	wire [7:0] char_bits;
	wire [15:0] line_format;
	host_bus_model u_host (.ref_clk, .waitrequest, .readdata, .address, .read, .write, .writedata, .byteenable);
	uart_irq_fifo_line_ctrl dut (.ref_clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .rx_count, .tx_count, .line_error_status({1'h0, lv[0]}),
		.modem_line_status({1'h0, lv[1]}), .xoff_match({1'h0, ev[0]}), .xon_match({1'h0, ev[1]}),
		.special_match({1'h0, ev[2]}), .rx_char_strobe({1'h0, ev[3]}), .flow_deassert({1'h0, ev[4]}),
		.flow_int_clear({1'h0, ev[5]}), .rx_hold_read({1'h0, ev[6]}), .tx_hold_write({1'h0, ev[7]}),
		.bit_tick({1'h0, ev[8]}), .fifo_enable, .dma_mode, .rx_fifo_reset, .tx_fifo_reset, .char_bits,
		.line_format, .enhanced_enable, .receive_ready_pin_n(rxp_n), .transmit_ready_pin_n(txp_n));
	// Clock and cycle ceiling
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		logic [31:0] d;
		u_host.bus_read(a, d);
		cmp8(d[7:0], exp);
	endtask
	task automatic w2;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'h1;
		@(posedge ref_clk);
		ev <= 9'h0;
		w2;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(6'h00, 8'h01);
		rd(6'h20, 8'h00);
		cmp8({2'h0, enhanced_enable, rxp_n, txp_n}, 8'h0F);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			u_host.bus_write(6'h08, i[7:0]);
			rd(6'h08, i[7:0]);
			cmp8({4'h0, char_bits[3:0]}, 8'h05 + i[7:0]);
		end
		u_host.bus_write(6'h04, 8'h06);
		rd(6'h00, 8'h01);
		u_host.bus_write(6'h04, 8'h09);
		rd(6'h00, 8'hC1);
		cmp8({7'h0, dma_mode[0]}, 8'h01);
		cmp8({4'h0, rxp_n, txp_n}, 8'h0E);
		u_host.bus_write(6'h04, 8'h07);
		$display("fifo control test done");
		tx_count[4:0] <= 5'h00;
		w2;
		rd(6'h00, 8'hC2);
		rd(6'h00, 8'hC1);
		lv <= 2'h3;
		rx_count[4:0] <= 5'h01;
		w2;
		rd(6'h00, 8'hC6);
		cmp8({4'h0, rxp_n, txp_n}, 8'h0A);
		lv <= 2'h2;
		w2;
		rd(6'h00, 8'hC4);
		rx_count[4:0] <= 5'h00;
		w2;
		rd(6'h00, 8'hC0);
		lv <= 2'h0;
		pulse(0);
		rd(6'h00, 8'hC1);
		u_host.bus_write(6'h0C, 8'h10);
		u_host.bus_write(6'h04, 8'h61);
		cmp8({6'h0, enhanced_enable}, 8'h01);
		pulse(0);
		rd(6'h00, 8'hD0);
		rd(6'h00, 8'hC1);
		pulse(2);
		pulse(3);
		rd(6'h00, 8'hC1);
		pulse(4);
		rd(6'h00, 8'hE0);
		pulse(5);
		rd(6'h00, 8'hC1);
		$display("priority test done");
		tx_count[4:0] <= 5'h08;
		w2;
		tx_count[4:0] <= 5'h07;
		w2;
		rd(6'h00, 8'hC2);
		pulse(7);
		rd(6'h00, 8'hC1);
		rx_count[4:0] <= 5'h01;
		repeat (51) pulse(8);
		rd(6'h00, 8'hC1);
		pulse(8);
		rd(6'h00, 8'hCC);
		pulse(6);
		rd(6'h00, 8'hC1);
		rx_count[4:0] <= 5'h04;
		w2;
		rd(6'h00, 8'hC4);
		rd(6'h10, 8'h01);
		u_host.bus_write(6'h04, 8'hF1);
		rx_count[4:0] <= 5'h0D;
		w2;
		rd(6'h00, 8'hC1);
		rx_count[4:0] <= 5'h0E;
		w2;
		rd(6'h00, 8'hC4);
		pulse(0);
		rd(6'h00, 8'hC4);
		rx_count[4:0] <= 5'h00;
		w2;
		rd(6'h00, 8'hD0);
		rd(6'h00, 8'hC1);
		$display("trigger and time-out test done");
		final_report;
	end
endmodule
